// [hdl/gasps_status_merge.sv]
// Combinational merge of individual alarms into status register images
`timescale 1ns/1ps
module gasps_status_merge (
   input  wire gasps_pkg::gasps_alarm_s alarms,
   input  wire logic                    conv_not_ready,
   input  wire logic                    amp_enable_state,
   output logic [15:0]                  general_status,
   output logic [15:0]                  channel_range_alarms
);

   logic any_converter_input_alarm;
   logic any_sense_input_alarm;

   assign any_converter_input_alarm = alarms.conv_input_one_range_alarm
                                    | alarms.conv_input_zero_range_alarm;
   assign any_sense_input_alarm = alarms.sense_input_one_range_alarm
                                | alarms.sense_input_zero_range_alarm;

   // Channel alarm image; everything else reads zero
   always_comb begin
      channel_range_alarms = gasps_pkg::RST_CHANNEL_ALARM;
      channel_range_alarms[gasps_pkg::CA_TEMP]   = alarms.temp_range_alarm;
      channel_range_alarms[gasps_pkg::CA_CONV1]  = alarms.conv_input_one_range_alarm;
      channel_range_alarms[gasps_pkg::CA_CONV0]  = alarms.conv_input_zero_range_alarm;
      channel_range_alarms[gasps_pkg::CA_SENSE1] = alarms.sense_input_one_range_alarm;
      channel_range_alarms[gasps_pkg::CA_SENSE0] = alarms.sense_input_zero_range_alarm;
   end

   // Summary image; reserved top nibble holds the fixed pattern
   always_comb begin
      general_status = 16'h0000;
      general_status[15:gasps_pkg::GS_RSVD_LO] = gasps_pkg::GEN_RSVD_PATTERN;
      general_status[gasps_pkg::GS_REF]    = |alarms.reference;
      general_status[gasps_pkg::GS_THERM]  = |alarms.overheat;
      general_status[gasps_pkg::GS_CONV]   = any_converter_input_alarm;
      general_status[gasps_pkg::GS_SENSE]  = any_sense_input_alarm;
      general_status[gasps_pkg::GS_NREADY] = conv_not_ready;
      general_status[gasps_pkg::GS_SUPPLY] = |alarms.supply;
      general_status[gasps_pkg::GS_PIN]    = alarms.external_alarm_input;
      general_status[gasps_pkg::GS_AMP]    = amp_enable_state;
      general_status[gasps_pkg::GS_TEMP]   = alarms.temp_range_alarm;
      general_status[gasps_pkg::GS_SUMMARY] = |alarms;
   end

endmodule

// [hdl/gasps_top.sv]
// Global page: page selector, general status, channel alarms and interrupt
// Function
// - Five-bit page selector decodes six pages
// - Global registers reachable from any page
// - Status bit 11 ORs reference alarms
// - Status bit 10 ORs overheat alarms
// - Status bit 9 ORs converter input alarms
// - Status bit 8 ORs sense input alarms
// - Status bit 7 is converter not-ready
// - Bit 5 supply OR; bit 3 alarm pin
// - Bit 2 mirrors amplifier enable output
// - Status bit 1 flags temperature alarm
// - Status bit 0 ORs every alarm
// - Channel alarm bit 8: temperature range
// - Channel alarm bits 5,4: converter inputs
// - Channel alarm bits 1,0: sense inputs
// - General status at 03h, reset 4000h
// - Channel alarms at 04h, zero, read-only
// - Page selector at 01h, resets zero
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
module gasps_top (
   input  wire logic                       clk,
   input  wire logic                       rst,
   input  wire logic [7:0]                 reg_addr,
   input  wire logic [15:0]                reg_wdata,
   input  wire logic                       reg_wr,
   input  wire logic                       reg_rd,
   output logic      [15:0]                reg_rdata,
   input  wire gasps_pkg::gasps_alarm_s    alarms_in,
   input  wire logic                       conv_not_ready_in,
   input  wire logic                       amp_enable_output,
   output gasps_pkg::gasps_page_dec_s      page_decode,
   output logic      [4:0]                 page_value,
   output logic                            irq
);

   localparam int AW = $bits(gasps_pkg::gasps_alarm_s);

   // Whole state of the block
   typedef struct packed {
      logic [AW-1:0]                     al_s1;
      logic [AW-1:0]                     al_s2;
      logic [1:0]                        rdy_sync;
      logic [1:0]                        amp_sync;
      logic [4:0]                        page;
      logic [15:0]                       gen;
      logic [15:0]                       chan;
      logic [15:0]                       rdata;
      logic [gasps_pkg::IRQ_WIDTH-1:0]   irq_stat;
      logic [gasps_pkg::IRQ_WIDTH-1:0]   irq_mask;
      logic                              prev_summary;
      logic                              prev_chan_any;
      logic                              prev_amp;
   } gasps_state_s;

   gasps_state_s state_r;
   gasps_state_s state_nxt;

   gasps_pkg::gasps_req_s req;
   logic [15:0]           gen_img;
   logic [15:0]           chan_img;
   logic [gasps_pkg::IRQ_WIDTH-1:0] events;
   logic                  chan_any;

   assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   // Status images come from doubly synchronised pin levels
   gasps_status_merge u_merge (
      .alarms               (gasps_pkg::gasps_alarm_s'(state_r.al_s2)),
      .conv_not_ready       (state_r.rdy_sync[1]),
      .amp_enable_state     (state_r.amp_sync[1]),
      .general_status       (gen_img),
      .channel_range_alarms (chan_img)
   );

   assign chan_any = |state_r.chan[8:0];

   // Events: rising summary, rising channel alarm, amplifier dropping off, page write
   always_comb begin
      events = '0;
      events[gasps_pkg::IRQ_SUMMARY] = state_r.gen[gasps_pkg::GS_SUMMARY]
                                       & ~state_r.prev_summary;
      events[gasps_pkg::IRQ_CHAN]    = chan_any & ~state_r.prev_chan_any;
      events[gasps_pkg::IRQ_AMP_OFF] = state_r.prev_amp & ~state_r.gen[gasps_pkg::GS_AMP];
      events[gasps_pkg::IRQ_PAGE]    = req.wr && (req.addr == gasps_pkg::ADDR_PAGE_SELECT);
   end

   // Next-state logic
   always_comb begin
      state_nxt = state_r;
      // Second flop only reads the first; nothing else looks at stage one
      state_nxt.al_s1    = alarms_in;
      state_nxt.al_s2    = state_r.al_s1;
      state_nxt.rdy_sync = {state_r.rdy_sync[0], conv_not_ready_in};
      state_nxt.amp_sync = {state_r.amp_sync[0], amp_enable_output};
      // Images refreshed each clock so a read never sees stale summaries
      state_nxt.gen  = gen_img;
      state_nxt.chan = chan_img;
      state_nxt.prev_summary  = state_r.gen[gasps_pkg::GS_SUMMARY];
      state_nxt.prev_chan_any = chan_any;
      state_nxt.prev_amp      = state_r.gen[gasps_pkg::GS_AMP];
      // Writes; global addresses decode without regard to page
      if (req.wr) begin
         case (req.addr)
            gasps_pkg::ADDR_PAGE_SELECT: state_nxt.page = req.wdata[4:0];
            gasps_pkg::ADDR_IRQ_MASK:
               state_nxt.irq_mask = req.wdata[gasps_pkg::IRQ_WIDTH-1:0];
            default: ;  // General status and channel alarms are read-only; writes dropped
         endcase
      end
      // Write-one-to-clear; a new event in the same cycle wins
      if (req.wr && (req.addr == gasps_pkg::ADDR_IRQ_STATUS)) begin
         state_nxt.irq_stat = state_r.irq_stat & ~req.wdata[gasps_pkg::IRQ_WIDTH-1:0];
      end
      state_nxt.irq_stat = state_nxt.irq_stat | events;
      // Read data valid the cycle after the strobe only
      state_nxt.rdata = 16'h0000;
      if (req.rd) begin
         case (req.addr)
            gasps_pkg::ADDR_PAGE_SELECT:   state_nxt.rdata = {11'h000, state_r.page};
            gasps_pkg::ADDR_GENERAL_STAT:  state_nxt.rdata = state_r.gen;
            gasps_pkg::ADDR_CHANNEL_ALARM: state_nxt.rdata = state_r.chan;
            gasps_pkg::ADDR_IRQ_STATUS:
               state_nxt.rdata = {12'h000, state_r.irq_stat};
            gasps_pkg::ADDR_IRQ_MASK:
               state_nxt.rdata = {12'h000, state_r.irq_mask};
            default: state_nxt.rdata = 16'h0000;
         endcase
      end
   end

   // State register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r          <= '0;
         state_r.page     <= gasps_pkg::RST_PAGE_SELECT;
         state_r.gen      <= gasps_pkg::RST_GENERAL_STAT;
         state_r.chan     <= gasps_pkg::RST_CHANNEL_ALARM;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Page decode for the paged register banks elsewhere in the device
   always_comb begin
      page_decode            = '0;
      page_decode.general    = (state_r.page == gasps_pkg::GASPS_PG_GENERAL);
      page_decode.converter  = (state_r.page == gasps_pkg::GASPS_PG_CONVERTER);
      page_decode.sequencer  = (state_r.page == gasps_pkg::GASPS_PG_SEQUENCER);
      page_decode.output_cfg = (state_r.page == gasps_pkg::GASPS_PG_OUTPUT);
      page_decode.out_buf    = (state_r.page == gasps_pkg::GASPS_PG_OUT_BUF);
      page_decode.out_act    = (state_r.page == gasps_pkg::GASPS_PG_OUT_ACT);
   end

   assign page_value = state_r.page;
   assign reg_rdata  = state_r.rdata;
   // Level interrupt while any unmasked sticky bit is set
   assign irq = |(state_r.irq_stat & state_r.irq_mask);

endmodule

// [inc/gasps_pkg.sv]
// Package: register map, field layout and carrier types of the global alarm/status page block
package gasps_pkg;

   // Register offsets (word addresses of the register port)
   localparam logic [7:0] ADDR_PAGE_SELECT   = 8'h01;
   localparam logic [7:0] ADDR_GENERAL_STAT  = 8'h03;
   localparam logic [7:0] ADDR_CHANNEL_ALARM = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STATUS    = 8'h08;
   localparam logic [7:0] ADDR_IRQ_MASK      = 8'h09;

   // Reset values
   localparam logic [15:0] RST_GENERAL_STAT  = 16'h4000;
   localparam logic [15:0] RST_CHANNEL_ALARM = 16'h0000;
   localparam logic [4:0]  RST_PAGE_SELECT   = 5'h00;
   localparam logic [3:0]  GEN_RSVD_PATTERN  = 4'h4;

   // General status field positions
   localparam int GS_REF     = 11;
   localparam int GS_THERM   = 10;
   localparam int GS_CONV    = 9;
   localparam int GS_SENSE   = 8;
   localparam int GS_NREADY  = 7;
   localparam int GS_SUPPLY  = 5;
   localparam int GS_PIN     = 3;
   localparam int GS_AMP     = 2;
   localparam int GS_TEMP    = 1;
   localparam int GS_SUMMARY = 0;
   localparam int GS_RSVD_LO = 12;

   // Channel alarm field positions
   localparam int CA_TEMP   = 8;
   localparam int CA_CONV1  = 5;
   localparam int CA_CONV0  = 4;
   localparam int CA_SENSE1 = 1;
   localparam int CA_SENSE0 = 0;

   // Interrupt status/mask bit positions
   localparam int IRQ_WIDTH   = 4;
   localparam int IRQ_SUMMARY = 0;
   localparam int IRQ_CHAN    = 1;
   localparam int IRQ_AMP_OFF = 2;
   localparam int IRQ_PAGE    = 3;

   // Page codes
   typedef enum logic [4:0] {
      GASPS_PG_GENERAL   = 5'h00,
      GASPS_PG_CONVERTER = 5'h01,
      GASPS_PG_SEQUENCER = 5'h02,
      GASPS_PG_OUTPUT    = 5'h03,
      GASPS_PG_OUT_BUF   = 5'h04,
      GASPS_PG_OUT_ACT   = 5'h06
   } gasps_page_e;

   // Page decode carried to the rest of the device; one-hot for the listed codes, all zero for unlisted codes
   typedef struct packed {
      logic general;
      logic converter;
      logic sequencer;
      logic output_cfg;
      logic out_buf;
      logic out_act;
   } gasps_page_dec_s;

   // Individual alarm sources
   typedef struct packed {
      logic [1:0] reference;
      logic [1:0] overheat;
      logic [3:0] supply;
      logic       external_alarm_input;
      logic       temp_range_alarm;
      logic       conv_input_one_range_alarm;
      logic       conv_input_zero_range_alarm;
      logic       sense_input_one_range_alarm;
      logic       sense_input_zero_range_alarm;
   } gasps_alarm_s;

   // Register port request
   typedef struct packed {
      logic [7:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } gasps_req_s;

endpackage

// [tb/gasps_exp_pkg.sv]
// Expected register images worked out from the alarm inputs
package gasps_exp_pkg;
   // Low twelve bits of general status; holes at bits 6 and 4 read zero
   function automatic logic [11:0] gen_img(gasps_pkg::gasps_alarm_s a, logic nr, logic amp);
      return {|a.reference, |a.overheat,
              a.conv_input_one_range_alarm | a.conv_input_zero_range_alarm,
              a.sense_input_one_range_alarm | a.sense_input_zero_range_alarm,
              nr, 1'h0, |a.supply, 1'h0, a.external_alarm_input, amp, a.temp_range_alarm, |a};
   endfunction
   // Channel alarm image; every other bit is reserved zero
   function automatic logic [15:0] chan_img(gasps_pkg::gasps_alarm_s a);
      return {7'h00, a.temp_range_alarm, 2'h0, a.conv_input_one_range_alarm,
              a.conv_input_zero_range_alarm, 2'h0, a.sense_input_one_range_alarm,
              a.sense_input_zero_range_alarm};
   endfunction
endpackage

// [tb/gasps_props.sv]
// Port-level properties of the global page block
`timescale 1ns/1ps
module gasps_props (
   input wire logic                       clk,
   input wire logic                       rst,
   input wire logic [7:0]                 reg_addr,
   input wire logic [15:0]                reg_wdata,
   input wire logic                       reg_wr,
   input wire logic                       reg_rd,
   input wire logic [15:0]                reg_rdata,
   input wire gasps_pkg::gasps_alarm_s    alarms_in,
   input wire logic                       conv_not_ready_in,
   input wire logic                       amp_enable_output,
   input wire gasps_pkg::gasps_page_dec_s page_decode,
   input wire logic [4:0]                 page_value,
   input wire logic                       irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence page_wr_s; reg_wr && reg_addr == 8'h01; endsequence
   sequence rd_s(logic [7:0] a); reg_rd && reg_addr == a; endsequence
   // Four quiet cycles cover the two-flop sync plus the image register
   sequence settled_s;
      ($stable(alarms_in) && $stable(conv_not_ready_in) && $stable(amp_enable_output))[*4];
   endsequence
   page_write_a: assert property (page_wr_s |=> page_value == $past(reg_wdata[4:0]))
      else $error("page value not taken from write");
   page_hold_a: assert property (!(reg_wr && reg_addr == 8'h01) |=> $stable(page_value))
      else $error("page value moved without write");
   page_decode_a: assert property (page_decode.general == (page_value == 5'h00)
      && page_decode.out_act == (page_value == 5'h06)) else $error("page decode wrong");
   page_read_a: assert property (rd_s(8'h01) |=> reg_rdata == {11'h000, $past(page_value)})
      else $error("page readback wrong");
   gen_rsvd_a: assert property (rd_s(8'h03) |=> reg_rdata[15:12] == 4'h4)
      else $error("status reserved bits wrong");
   gen_image_a: assert property (settled_s ##0 rd_s(8'h03) |=> reg_rdata[11:0] ==
      gasps_exp_pkg::gen_img($past(alarms_in), $past(conv_not_ready_in), $past(amp_enable_output)))
      else $error("general status image wrong");
   chan_image_a: assert property (settled_s ##0 rd_s(8'h04) |=>
      reg_rdata == gasps_exp_pkg::chan_img($past(alarms_in))) else $error("channel image wrong");
   idle_rdata_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data not zero outside read");
endmodule
bind gasps_top gasps_props u_props (.clk(clk), .rst(rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .alarms_in(alarms_in), .conv_not_ready_in(conv_not_ready_in),
   .amp_enable_output(amp_enable_output), .page_decode(page_decode),
   .page_value(page_value), .irq(irq));

// [tb/test_global_alarm_status_page_select.sv]
// Self-checking testbench of the global page block
`timescale 1ns/1ps
module test_global_alarm_status_page_select;
   logic                       clk = 1'h0;
   logic                       rst = 1'h1;
   logic                       reg_wr = 1'h0;
   logic                       reg_rd = 1'h0;
   logic                       nr = 1'h0;
   logic                       amp = 1'h0;
   logic [7:0]                 reg_addr = 8'h00;
   logic [15:0]                reg_wdata = 16'h0000;
   logic [15:0]                reg_rdata;
   logic [4:0]                 page_value;
   logic                       irq;
   logic [5:0]                 exp_dec;
   gasps_pkg::gasps_alarm_s    al = '0;
   gasps_pkg::gasps_page_dec_s pdec;
   int                         errors = 0;
   int                         cmp_count = 0;
   int                         i;

   gasps_top uut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .alarms_in(al),
      .conv_not_ready_in(nr), .amp_enable_output(amp), .page_decode(pdec),
      .page_value(page_value), .irq(irq));

   // 25 MHz clock
   always #20 clk = ~clk;

   task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // One-cycle write strobe, dropped at the edge that takes it
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'h0;
   endtask
   // Read data stand only in the cycle after the strobe, so sample just past that edge
   task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string what);
      @(posedge clk);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'h0;
      #1 chk16(reg_rdata, exp, what);
   endtask
   // Irq is combinational from the registered status and mask bits; three edges is ample
   task automatic chk_irq(input logic exp);
      repeat (3) @(posedge clk);
      #1 chk16({15'h0000, irq}, {15'h0000, exp}, "irq level");
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'h0;
      rd(8'h03, 16'h4000, "gen reset");
      rd(8'h04, 16'h0000, "chan reset");
      rd(8'h01, 16'h0000, "page reset");
      rd(8'h20, 16'h0000, "unmapped read");
      $display("test reset done");
      // Page codes 0 to 7, listed and unlisted, with global reads on each page
      for (i = 0; i < 8; i++) begin
         wr(8'h01, 16'(i));
         exp_dec = (i < 5) ? 6'h20 >> i : (i == 6) ? 6'h01 : 6'h00;
         #1 chk16({10'h000, pdec}, {10'h000, exp_dec}, "decode");
         rd(8'h01, 16'(i), "page readback");
         rd(8'h03, 16'h4000, "gen on page");
         rd(8'h04, 16'h0000, "chan on page");
      end
      wr(8'h03, 16'hffff);
      wr(8'h04, 16'hffff);
      wr(8'h20, 16'hffff);
      rd(8'h03, 16'h4000, "gen read-only");
      rd(8'h04, 16'h0000, "chan read-only");
      rd(8'h01, 16'h0007, "page kept");
      $display("test page done");
      // Walk one alarm source at a time, then not-ready and amplifier enable
      for (i = 0; i < 17; i++) begin
         @(posedge clk);
         al <= gasps_pkg::gasps_alarm_s'(14'h0001 << i);
         nr <= (i == 14);
         amp <= (i == 15);
         repeat (4) @(posedge clk);
         rd(8'h03, {4'h4, gasps_exp_pkg::gen_img(al, nr, amp)}, "gen image");
         rd(8'h04, gasps_exp_pkg::chan_img(al), "chan image");
      end
      $display("test alarms done");
      // Sticky status, mask and write-one-to-clear; a set mask bit lets its status through
      // Walk above raised summary, channel and amplifier-off events, page loop the page event
      rd(8'h08, 16'h000f, "irq sticky");
      wr(8'h09, 16'h0000);
      wr(8'h08, 16'h000f);
      chk_irq(1'h0);
      rd(8'h08, 16'h0000, "irq clear all");
      wr(8'h01, 16'h0003);
      chk_irq(1'h0);
      rd(8'h08, 16'h0008, "irq status");
      wr(8'h09, 16'h0008);
      chk_irq(1'h1);
      rd(8'h09, 16'h0008, "irq mask");
      wr(8'h09, 16'h0000);
      chk_irq(1'h0);
      wr(8'h09, 16'h0008);
      chk_irq(1'h1);
      wr(8'h08, 16'h0008);
      chk_irq(1'h0);
      rd(8'h08, 16'h0000, "irq cleared");
      $display("test irq done");
      tally_and_finish;
   end

   // Watchdog well past the few hundred cycles the tests need
   initial begin
      repeat (5000) @(posedge clk);
      errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      tally_and_finish;
   end
endmodule
